// ==== common/sat_pkg.sv ====
/*
 * Shared constants for the serial channel: register offsets, field
 * positions, reset values, oversampling figures and state encodings.
 * Assumes a byte-wide register port with a three-bit address.
 */
package sat_pkg;
	localparam int          ADDR_W     = 3;
	localparam logic [2:0]  OFS_MODE   = 3'h0;
	localparam logic [2:0]  OFS_DIV    = 3'h1;
	localparam logic [2:0]  OFS_CTRL   = 3'h2;
	localparam logic [2:0]  OFS_TXD    = 3'h3;
	localparam logic [2:0]  OFS_STAT   = 3'h4;
	localparam logic [2:0]  OFS_RXD    = 3'h5;
	// Mode register fields.
	localparam int          M_SYNC     = 7;
	localparam int          M_CHR      = 6;
	localparam int          M_PE       = 5;
	localparam int          M_ODD      = 4;
	localparam int          M_STOP     = 3;
	// Control register fields.
	localparam int          C_TIE      = 7;
	localparam int          C_RIE      = 6;
	localparam int          C_TE       = 5;
	localparam int          C_RE       = 4;
	localparam int          C_CLOCK_ENABLE_HIGH     = 1;
	localparam int          C_CLOCK_ENABLE_LOW     = 0;
	// Status register fields.
	localparam int          S_TX_EMPTY_FLAG     = 7;
	localparam int          S_RX_FULL_FLAG     = 6;
	localparam int          S_OVERRUN_FLAG     = 5;
	localparam int          S_FER      = 4;
	localparam int          S_PER      = 3;
	localparam logic [7:0]  MODE_RST   = 8'h00;
	localparam logic [7:0]  DIV_RST    = 8'hFF;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [3:0]  OS_MID     = 4'h7;
	localparam logic [3:0]  OS_LAST    = 4'hF;
	localparam logic [3:0]  SYNC_BITS  = 4'h8;
	localparam logic [11:0] ALL_ONES   = 12'hFFF;

	typedef enum logic [3:0] {
		TX_OFF   = 4'b0001,
		TX_PRE   = 4'b0010,
		TX_IDLE  = 4'b0100,
		TX_SHIFT = 4'b1000
	} sat_tx_t;

	typedef enum logic [3:0] {
		RX_OFF   = 4'b0001,
		RX_HUNT  = 4'b0010,
		RX_START = 4'b0100,
		RX_BITS  = 4'b1000
	} sat_rx_t;
endpackage

// ==== logic/sat_baud.sv ====
/*
 * Baud-rate generator: a prescaler of 4, 16, 64 or 256 cycles followed
 * by a divide by divisor plus one, giving one enable pulse per period.
 * Assumes the caller holds run low while the channel is reinitialised.
 */
`timescale 1ns/1ps
module sat_baud (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [1:0] cks,
	input  wire logic [7:0] divisor,
	output logic            tick
);
	logic [7:0] pre_r;
	logic [7:0] div_r;
	logic [7:0] pre_top;
	logic       pre_wrap;

	// The prescale covers the fixed factor of four in both modes.
	always_comb begin
		unique case (cks)
			2'h0: pre_top = 8'h03;
			2'h1: pre_top = 8'h0F;
			2'h2: pre_top = 8'h3F;
			2'h3: pre_top = 8'hFF;
		endcase
	end

	assign pre_wrap = (pre_r == pre_top);
	assign tick     = pre_wrap && (div_r == divisor);

	always_ff @(posedge core_clk) begin
		if (sys_rst || !run || pre_wrap) begin
			pre_r <= 8'h00;
		end else begin
			pre_r <= pre_r + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !run || tick) begin
			div_r <= 8'h00;
		end else if (pre_wrap) begin
			div_r <= div_r + 8'h01;
		end
	end
endmodule

// ==== logic/sat_channel.sv ====
/*
 * Serial channel top: register port, transmitter, receiver, status
 * flags and request outputs for asynchronous and synchronous modes.
 * Assumes all pins and register strobes are synchronous to core_clk.
 */
// Overview of operation
// - Transmit enable drives the pin and, in async mode, sends one all-ones frame first.
// - Frame: start 0, 7 or 8 data LSB first, optional parity, stops.
// - Holding-to-shift move sets tx_empty_flag and requests tx_end_irq.
// - Enabled async transmitter with empty holding register and idle shifter drives the pin high.
// - Receiver aligns on start bit, shifts bits in, checks stop bit.
// - Good frame goes to holding register, top bit cleared for 7-bit.
// - rx_full_flag clears by armed status write or transfer controller read.
// - Receive errors leave rx_full_flag alone and set error flags.
// - Framing or parity errors still transfer; overrun discards the frame.
// - Every error seen in one frame is flagged together.
// - Error flags clear only by writing 0 after reading the status.
// - Overrun when a frame completes while rx_full_flag is still set.
// - Parity mismatch sets parity flag; a 0 stop bit sets framing flag.
// - Synchronous transfers are eight data bits only, LSB first.
// - Synchronous data changes on falling clock, is captured on rising.
// - Synchronous clock is internal and driven out, or external input.
// - Transmitter and receiver run independently, each double-buffered.
// - Asynchronous bits are sampled on the eighth of sixteen ticks.
// - Mode bits select 7 bits, parity and two stop bits.
`timescale 1ns/1ps
module sat_channel (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       xfer_rd,
	input  wire logic       rxd_in,
	output logic            txd_out,
	output logic            txd_oe,
	input  wire logic       sclk_in,
	output logic            sclk_out,
	output logic            sclk_oe,
	output logic            tx_end_irq,
	output logic            rx_end_irq,
	output logic            rx_error_irq
);
	logic [7:0]   mode_r, div_r, ctrl_r, tx_hold_r, rx_hold_r;
	logic         tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r;
	logic [4:0]   arm_r;
	sat_pkg::sat_tx_t tx_st_r;
	sat_pkg::sat_rx_t rx_st_r;
	logic [11:0]  tx_sr_r;
	logic [3:0]   tx_cnt_r, tx_os_r, rx_os_r, rx_idx_r;
	logic [7:0]   rx_sr_r;
	logic         rx_par_r, rx_ferr_r, rx_prev_r, sclk_d_r, sclk_int_r;
	logic         sync_m, chr7, pe, ext_clk, tx_en, rx_en;
	logic         brg_tick, os_tick, sclk_rise, sclk_fall, int_sync_run;
	logic         tx_step, tx_load, tx_done, rx_sample, rx_done;
	logic         rx_fe, rx_pe;
	logic [7:0]   rx_byte;
	logic [11:0]  frame;
	logic [3:0]   frame_len, rx_last, d_len;
	logic         st_wr, st_rd;

	assign sync_m  = mode_r[sat_pkg::M_SYNC];
	assign chr7    = mode_r[sat_pkg::M_CHR] && !sync_m;
	assign pe      = mode_r[sat_pkg::M_PE] && !sync_m;
	assign ext_clk = ctrl_r[sat_pkg::C_CLOCK_ENABLE_HIGH];
	assign tx_en   = ctrl_r[sat_pkg::C_TE];
	assign rx_en   = ctrl_r[sat_pkg::C_RE];
	assign st_wr   = reg_wr && (reg_addr == sat_pkg::OFS_STAT);
	assign st_rd   = reg_rd && (reg_addr == sat_pkg::OFS_STAT);

	// The generator idles while both directions are off, so a new
	// divisor takes effect cleanly at the next enable.
	sat_baud u_baud (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.run      (tx_en || rx_en),
		.cks      (mode_r[1:0]),
		.divisor  (div_r),
		.tick     (brg_tick)
	);

	// The internal synchronous clock only runs while there is work.
	assign int_sync_run = sync_m && !ext_clk &&
		((tx_st_r == sat_pkg::TX_SHIFT) || rx_en);
	assign sclk_rise = ext_clk ? (sclk_in && !sclk_d_r)
		: (brg_tick && int_sync_run && !sclk_int_r);
	assign sclk_fall = ext_clk ? (!sclk_in && sclk_d_r)
		: (brg_tick && int_sync_run && sclk_int_r);
	// External asynchronous clock is sixteen times the bit rate.
	assign os_tick = ext_clk ? (sclk_in && !sclk_d_r) : brg_tick;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sclk_d_r   <= 1'b1;
			sclk_int_r <= 1'b1;
			rx_prev_r  <= 1'b1;
		end else begin
			sclk_d_r  <= sclk_in;
			rx_prev_r <= rxd_in;
			if (!int_sync_run) begin
				sclk_int_r <= 1'b1;
			end else if (brg_tick) begin
				sclk_int_r <= !sclk_int_r;
			end
		end
	end

	// Frame layout after the start bit; unused upper bits stay at one.
	always_comb begin
		frame = sat_pkg::ALL_ONES;
		if (sync_m) begin
			frame[7:0] = tx_hold_r;
		end else if (chr7) begin
			frame[6:0] = tx_hold_r[6:0];
			frame[7]   = !pe || (^tx_hold_r[6:0] ^ mode_r[sat_pkg::M_ODD]);
		end else begin
			frame[7:0] = tx_hold_r;
			frame[8]   = !pe || (^tx_hold_r ^ mode_r[sat_pkg::M_ODD]);
		end
		d_len     = chr7 ? 4'h7 : 4'h8;
		frame_len = 4'h2 + d_len + {3'h0, pe}
			+ {3'h0, mode_r[sat_pkg::M_STOP]};
	end

	// Async bits last sixteen ticks; sync bits move on falling edges.
	assign tx_step = sync_m ? sclk_fall
		: (os_tick && tx_os_r == sat_pkg::OS_LAST);
	assign tx_done = tx_step && (tx_cnt_r == 4'h1);
	assign tx_load = !tx_empty_flag_r && ((tx_st_r == sat_pkg::TX_IDLE)
		|| (tx_st_r == sat_pkg::TX_SHIFT && tx_done));

	always_ff @(posedge core_clk) begin
		if (sys_rst || !tx_en) begin
			tx_os_r <= 4'h0;
		end else if (tx_load) begin
			tx_os_r <= 4'h0;
		end else if (os_tick) begin
			tx_os_r <= tx_os_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_st_r  <= sat_pkg::TX_OFF;
			tx_sr_r  <= sat_pkg::ALL_ONES;
			tx_cnt_r <= 4'h0;
			txd_out  <= 1'b1;
		end else if (!tx_en) begin
			tx_st_r <= sat_pkg::TX_OFF;
			txd_out <= 1'b1;
		end else begin
			unique case (tx_st_r)
				sat_pkg::TX_OFF: begin
					// In async mode, one all-ones frame before data is accepted.
					tx_st_r  <= sync_m ? sat_pkg::TX_IDLE : sat_pkg::TX_PRE;
					tx_sr_r  <= sat_pkg::ALL_ONES;
					tx_cnt_r <= frame_len;
					txd_out  <= 1'b1;
				end
				sat_pkg::TX_PRE: begin
					if (tx_done) begin
						tx_st_r <= sat_pkg::TX_IDLE;
					end else if (tx_step) begin
						tx_cnt_r <= tx_cnt_r - 4'h1;
					end
				end
				sat_pkg::TX_IDLE, sat_pkg::TX_SHIFT: begin
					if (tx_load) begin
						tx_st_r <= sat_pkg::TX_SHIFT;
						if (sync_m) begin
							tx_sr_r  <= frame;
							tx_cnt_r <= sat_pkg::SYNC_BITS + 4'h1;
						end else begin
							tx_sr_r  <= frame;
							tx_cnt_r <= frame_len;
							txd_out  <= 1'b0;
						end
					end else if (tx_done) begin
						// Sync holds the last bit; async ends on a stop bit.
						tx_st_r <= sat_pkg::TX_IDLE;
					end else if (tx_st_r == sat_pkg::TX_SHIFT && tx_step) begin
						txd_out  <= tx_sr_r[0];
						tx_sr_r  <= {1'b1, tx_sr_r[11:1]};
						tx_cnt_r <= tx_cnt_r - 4'h1;
					end
				end
			endcase
		end
	end

	// Receiver. Async sampling is on the eighth tick of each bit.
	assign rx_last   = d_len + {3'h0, pe} + {3'h0, mode_r[sat_pkg::M_STOP]};
	assign rx_sample = os_tick && rx_os_r == sat_pkg::OS_MID && !sync_m;
	assign rx_done   = rx_en && (sync_m
		? (rx_st_r == sat_pkg::RX_BITS && sclk_rise
			&& rx_idx_r == sat_pkg::SYNC_BITS - 4'h1)
		: (rx_st_r == sat_pkg::RX_BITS && rx_sample
			&& rx_idx_r == rx_last));
	assign rx_byte = sync_m ? {rxd_in, rx_sr_r[6:0]}
		: {rx_sr_r[7] && !chr7, rx_sr_r[6:0]};
	assign rx_fe = !sync_m && (rx_ferr_r || !rxd_in);
	assign rx_pe = pe && ((^rx_byte ^ rx_par_r)
		!= mode_r[sat_pkg::M_ODD]);

	always_ff @(posedge core_clk) begin
		if (sys_rst || rx_st_r == sat_pkg::RX_HUNT || !rx_en) begin
			rx_os_r <= 4'h0;
		end else if (os_tick) begin
			rx_os_r <= rx_os_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_st_r   <= sat_pkg::RX_OFF;
			rx_idx_r  <= 4'h0;
			rx_sr_r   <= 8'h00;
			rx_par_r  <= 1'b0;
			rx_ferr_r <= 1'b0;
		end else if (!rx_en) begin
			rx_st_r <= sat_pkg::RX_OFF;
		end else begin
			unique case (rx_st_r)
				sat_pkg::RX_OFF: begin
					rx_st_r  <= sync_m ? sat_pkg::RX_BITS : sat_pkg::RX_HUNT;
					rx_idx_r <= 4'h0;
				end
				sat_pkg::RX_HUNT: begin
					if (rx_prev_r && !rxd_in) begin
						rx_st_r <= sat_pkg::RX_START;
					end
				end
				sat_pkg::RX_START: begin
					if (rx_sample) begin
						// A start bit gone high again was only a glitch.
						rx_st_r   <= rxd_in ? sat_pkg::RX_HUNT
							: sat_pkg::RX_BITS;
						rx_idx_r  <= 4'h0;
						rx_ferr_r <= 1'b0;
						rx_par_r  <= 1'b0;
					end
				end
				sat_pkg::RX_BITS: begin
					if (rx_done) begin
						rx_st_r  <= sync_m ? sat_pkg::RX_BITS
							: sat_pkg::RX_HUNT;
						rx_idx_r <= 4'h0;
					end else if (sync_m ? sclk_rise : rx_sample) begin
						rx_idx_r <= rx_idx_r + 4'h1;
						if (rx_idx_r < d_len) begin
							rx_sr_r[rx_idx_r[2:0]] <= rxd_in;
						end else if (pe && rx_idx_r == d_len) begin
							rx_par_r <= rxd_in;
						end else if (!rxd_in) begin
							rx_ferr_r <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Register writes.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_r    <= sat_pkg::MODE_RST;
			div_r     <= sat_pkg::DIV_RST;
			ctrl_r    <= sat_pkg::CTRL_RST;
			tx_hold_r <= 8'h00;
		end else if (reg_wr) begin
			unique case (reg_addr)
				sat_pkg::OFS_MODE: mode_r    <= reg_wdata;
				sat_pkg::OFS_DIV:  div_r     <= reg_wdata;
				sat_pkg::OFS_CTRL: ctrl_r    <= reg_wdata;
				sat_pkg::OFS_TXD:  tx_hold_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// A status write clears a flag only after a status read that saw it set.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			arm_r <= 5'h00;
		end else if (st_rd) begin
			arm_r <= {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r};
		end else if (st_wr) begin
			arm_r <= arm_r & reg_wdata[7:3];
		end
	end

	// Hardware set wins over a software clear in the same cycle.
	always_ff @(posedge core_clk) begin
		if (sys_rst || !tx_en) begin
			tx_empty_flag_r <= 1'b1;
		end else if (tx_load) begin
			tx_empty_flag_r <= 1'b1;
		end else if (st_wr && arm_r[4] && !reg_wdata[sat_pkg::S_TX_EMPTY_FLAG]) begin
			tx_empty_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_full_flag_r    <= 1'b0;
			overrun_flag_r    <= 1'b0;
			fer_r     <= 1'b0;
			per_r     <= 1'b0;
			rx_hold_r <= 8'h00;
		end else begin
			if (rx_done && !rx_full_flag_r) begin
				rx_hold_r <= rx_byte;
			end
			if (rx_done && !rx_full_flag_r && !rx_fe && !rx_pe) begin
				rx_full_flag_r <= 1'b1;
			end else if (xfer_rd || (st_wr && arm_r[3]
				&& !reg_wdata[sat_pkg::S_RX_FULL_FLAG])) begin
				rx_full_flag_r <= 1'b0;
			end
			if (rx_done && rx_full_flag_r) begin
				overrun_flag_r <= 1'b1;
			end else if (st_wr && arm_r[2] && !reg_wdata[sat_pkg::S_OVERRUN_FLAG]) begin
				overrun_flag_r <= 1'b0;
			end
			if (rx_done && rx_fe) begin
				fer_r <= 1'b1;
			end else if (st_wr && arm_r[1] && !reg_wdata[sat_pkg::S_FER]) begin
				fer_r <= 1'b0;
			end
			if (rx_done && rx_pe) begin
				per_r <= 1'b1;
			end else if (st_wr && arm_r[0] && !reg_wdata[sat_pkg::S_PER]) begin
				per_r <= 1'b0;
			end
		end
	end

	// Registered outputs: read data, pin drivers, clock pin, requests.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata    <= 8'h00;
			txd_oe       <= 1'b0;
			sclk_out     <= 1'b1;
			sclk_oe      <= 1'b0;
			tx_end_irq   <= 1'b0;
			rx_end_irq   <= 1'b0;
			rx_error_irq <= 1'b0;
		end else begin
			txd_oe <= tx_en;
			// Async clock output rises mid-bit; sync follows the bit clock.
			sclk_out <= sync_m ? sclk_int_r
				: (tx_st_r != sat_pkg::TX_SHIFT || tx_os_r[3]);
			sclk_oe  <= !ext_clk && (sync_m || ctrl_r[sat_pkg::C_CLOCK_ENABLE_LOW])
				&& (tx_en || rx_en);
			tx_end_irq   <= tx_empty_flag_r && tx_en && ctrl_r[sat_pkg::C_TIE];
			rx_end_irq   <= rx_full_flag_r && ctrl_r[sat_pkg::C_RIE];
			rx_error_irq <= (overrun_flag_r || fer_r || per_r)
				&& ctrl_r[sat_pkg::C_RIE];
			if (reg_rd) begin
				unique case (reg_addr)
					sat_pkg::OFS_MODE: reg_rdata <= mode_r;
					sat_pkg::OFS_DIV:  reg_rdata <= div_r;
					sat_pkg::OFS_CTRL: reg_rdata <= ctrl_r;
					sat_pkg::OFS_TXD:  reg_rdata <= tx_hold_r;
					sat_pkg::OFS_STAT: reg_rdata <= {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r,
						fer_r, per_r, 3'h0};
					sat_pkg::OFS_RXD:  reg_rdata <= rx_hold_r;
					default:           reg_rdata <= 8'h00;
				endcase
			end else if (xfer_rd) begin
				reg_rdata <= rx_hold_r;
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	property p_load_empty;
		@(posedge core_clk) disable iff (sys_rst)
		tx_load |=> tx_empty_flag_r && tx_st_r == sat_pkg::TX_SHIFT;
	endproperty
	a_load_empty: assert property (p_load_empty) else $error("no empty flag after load");

	property p_start_low;
		@(posedge core_clk) disable iff (sys_rst)
		tx_load && !sync_m && tx_en |=> !txd_out;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_pre_ones;
		@(posedge core_clk) disable iff (sys_rst)
		tx_st_r == sat_pkg::TX_PRE |-> txd_out && txd_oe;
	endproperty
	a_pre_ones: assert property (p_pre_ones) else $error("idle frame not ones");

	property p_idle_high;
		@(posedge core_clk) disable iff (sys_rst)
		tx_en && !sync_m && tx_empty_flag_r && tx_st_r == sat_pkg::TX_IDLE
			&& $past(tx_st_r) == sat_pkg::TX_IDLE |-> txd_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle pin not high");

	property p_good_frame;
		@(posedge core_clk) disable iff (sys_rst)
		rx_done && !rx_full_flag_r && !rx_fe && !rx_pe |=> rx_full_flag_r ##1 rx_end_irq
			|| !ctrl_r[sat_pkg::C_RIE];
	endproperty
	a_good_frame: assert property (p_good_frame) else $error("good frame lost");

	property p_seven_bit;
		@(posedge core_clk) disable iff (sys_rst)
		rx_done && !rx_full_flag_r && chr7 |=> !rx_hold_r[7];
	endproperty
	a_seven_bit: assert property (p_seven_bit) else $error("7-bit top not zero");

	property p_overrun;
		@(posedge core_clk) disable iff (sys_rst)
		rx_done && rx_full_flag_r |=> overrun_flag_r && $stable(rx_hold_r);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun mishandled");

	property p_err_nofull;
		@(posedge core_clk) disable iff (sys_rst)
		rx_done && !rx_full_flag_r && (rx_fe || rx_pe) |=> !rx_full_flag_r
			&& (fer_r || per_r);
	endproperty
	a_err_nofull: assert property (p_err_nofull) else $error("error set full");

	property p_err_clear;
		@(posedge core_clk) disable iff (sys_rst)
		$fell(fer_r) |-> $past(st_wr) && $past(arm_r[1]);
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("unarmed clear");

	// Ticks since the start edge, counted apart from the sampler itself.
	logic [3:0] start_ticks_r;
	always_ff @(posedge core_clk) begin
		if (sys_rst || rx_st_r != sat_pkg::RX_START) begin
			start_ticks_r <= 4'h0;
		end else if (os_tick) begin
			start_ticks_r <= start_ticks_r + 4'h1;
		end
	end

	property p_mid_sample;
		@(posedge core_clk) disable iff (sys_rst)
		rx_st_r == sat_pkg::RX_START && rx_sample |-> start_ticks_r == 4'h7;
	endproperty
	a_mid_sample: assert property (p_mid_sample) else $error("sample off centre");

	c_tx_frame: cover property (@(posedge core_clk) tx_load ##[1:1000] tx_done);
	c_rx_good:  cover property (@(posedge core_clk) rx_done && !rx_full_flag_r);
	c_overrun:  cover property (@(posedge core_clk) rx_done && rx_full_flag_r);
	c_sync_rx:  cover property (@(posedge core_clk) rx_done && sync_m);
endmodule

// ==== tb/sat_remote.sv ====
/* Remote serial device at the channel's data and clock pins.
   Assumes a bit time of bit_cyc cycles; its clock runs at 16 per bit. */
`timescale 1ns/1ps
module sat_remote (
	input  wire logic core_clk,
	input  wire logic txd_out,
	input  wire logic sclk_out,
	output logic      rxd,
	output logic      sclk
);
	int  bit_cyc = 64;
	time t_start;
	initial rxd = 1'b1;
	// The far clock never stops, so reinitialisation always sees it.
	initial sclk = 1'b1;
	always begin
		repeat (2) @(posedge core_clk);
		sclk <= ~sclk;
	end
	task automatic put(input logic b);
		rxd <= b;
		repeat (bit_cyc) @(posedge core_clk);
	endtask
	// Corrupt parity or stop bits go out only when a test asks for them.
	task automatic send(input logic [7:0] d, input int nb, input logic pe,
		input logic odd, input int ns, input logic pbad, input logic sbad);
		int i;
		@(posedge core_clk);
		put(1'b0);
		for (i = 0; i < nb; i++) put(d[i]);
		if (pe) put(^(d & (nb == 7 ? 8'h7F : 8'hFF)) ^ odd ^ pbad);
		for (i = 0; i < ns; i++) put(~sbad);
		rxd <= 1'b1;
	endtask
	// Falling edges keep the samples clear of the design's own updates.
	task automatic grab(input int nb, input logic pe, output logic [7:0] d,
		output logic p, output logic s, output logic [1:0] c);
		int i;
		d = 8'h00;
		p = 1'b0;
		do @(negedge core_clk); while (txd_out !== 1'b0);
		t_start = $time;
		repeat (bit_cyc / 4) @(negedge core_clk);
		c[1] = sclk_out;
		repeat (bit_cyc / 4) @(negedge core_clk);
		for (i = 0; i < nb; i++) begin
			repeat (bit_cyc) @(negedge core_clk);
			d[i] = txd_out;
		end
		if (pe) begin
			repeat (bit_cyc) @(negedge core_clk);
			p = txd_out;
		end
		repeat (bit_cyc) @(negedge core_clk);
		s = txd_out;
		repeat (bit_cyc / 4) @(negedge core_clk);
		c[0] = sclk_out;
	endtask
	// Synchronous bits are taken just after each rising clock edge.
	task automatic grab_sync(output logic [7:0] d);
		int i;
		d = 8'h00;
		@(negedge sclk);
		for (i = 0; i < 8; i++) begin
			@(posedge sclk);
			@(negedge core_clk);
			d[i] = txd_out;
		end
	endtask
endmodule

// ==== tb/sat_channel_bench.sv ====
/* Self-checking bench for the serial channel: register master and a
   remote device. Assumes divisor 0 and prescale 0, or the remote clock. */
`timescale 1ns/1ps
module sat_channel_bench;
	logic       core_clk    = 1'b0;
	logic       sys_rst     = 1'b1;
	logic [2:0] reg_addr    = 3'h0;
	logic [7:0] reg_wdata   = 8'h00;
	logic       reg_wr      = 1'b0;
	logic       reg_rd      = 1'b0;
	logic       xfer_rd     = 1'b0;
	logic [7:0] reg_rdata;
	logic       rxd_in;
	logic       txd_out;
	logic       txd_oe;
	logic       tx_irq;
	logic       rx_irq;
	logic       er_irq;
	logic       sclk;
	logic       sclk_out;
	logic       sclk_oe;
	int         error_cnt   = 0;
	int         checks_done = 0;
	int         cyc         = 0;
	always #12.5 core_clk = ~core_clk;
	sat_channel u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_rd(xfer_rd),
		.rxd_in(rxd_in), .txd_out(txd_out), .txd_oe(txd_oe),
		.sclk_in(sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.tx_end_irq(tx_irq),
		.rx_end_irq(rx_irq), .rx_error_irq(er_irq));
	sat_remote u_remote (.core_clk(core_clk), .txd_out(txd_out),
		.sclk_out(sclk_out), .rxd(rxd_in), .sclk(sclk));
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Each access leaves one idle cycle so no strobe is set twice at once.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic x);
		if (x)
			xfer_rd <= 1'b1;
		else begin
			reg_addr <= a;
			reg_rd   <= 1'b1;
		end
		@(posedge core_clk);
		reg_rd  <= 1'b0;
		xfer_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge core_clk);
	endtask
	function automatic logic [7:0] msk(input logic [7:0] d, input int nb);
		return (nb == 7) ? {1'b0, d[6:0]} : d;
	endfunction
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		logic [7:0] d, t, g;
		logic       p, s, lo, odd, pe, ext;
		logic [1:0] c;
		int         i, nb, ns, nf;
		time        t_en;
		i = $urandom(1613);
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(sat_pkg::OFS_MODE, sat_pkg::MODE_RST, 1'b0);
		rd(sat_pkg::OFS_DIV, sat_pkg::DIV_RST, 1'b0);
		rd(sat_pkg::OFS_CTRL, sat_pkg::CTRL_RST, 1'b0);
		rd(sat_pkg::OFS_STAT, 8'h80, 1'b0);
		wr(3'h7, 8'hA5);
		rd(3'h7, 8'h00, 1'b0);
		for (int f = 0; f < 8; f++) begin
			nb  = f[2] ? 7 : 8;
			pe  = f[1];
			ns  = f[0] + 1;
			ext = f[0] ^ f[2];
			nf  = 1 + nb + pe + ns;
			odd = 1'($urandom);
			d   = 8'($urandom);
			t   = 8'($urandom);
			wr(sat_pkg::OFS_CTRL, 8'h00);
			wr(sat_pkg::OFS_MODE, {1'b0, f[2:1], odd, f[0], 3'b000});
			wr(sat_pkg::OFS_DIV, 8'h00);
			repeat (64) @(posedge core_clk);
			wr(sat_pkg::OFS_CTRL, ext ? 8'hF2 : 8'hF1);
			t_en = $time - 25;
			#1 chk({6'h00, txd_oe, sclk_oe}, {6'h00, 1'b1, !ext});
			wr(sat_pkg::OFS_TXD, t);
			rd(sat_pkg::OFS_STAT, 8'h80, 1'b0);
			wr(sat_pkg::OFS_STAT, 8'h7F);
			fork
				u_remote.send(d, nb, pe, odd, ns, 1'b0, 1'b0);
				u_remote.grab(nb, pe, g, p, s, c);
			join
			chk({6'h00, c}, 8'h01);
			chk({7'h00, u_remote.t_start >= t_en + nf * 1600 - 100}, 8'h01);
			chk(g, msk(t, nb));
			chk({6'h00, p, s}, {6'h00, pe ? ^msk(t, nb) ^ odd : 1'b0, 1'b1});
			chk({7'h00, tx_irq}, 8'h01);
			chk({7'h00, rx_irq}, 8'h01);
			rd(sat_pkg::OFS_STAT, 8'hC0, 1'b0);
			if (f % 2)
				rd(3'h0, msk(d, nb), 1'b1);
			else begin
				rd(sat_pkg::OFS_RXD, msk(d, nb), 1'b0);
				wr(sat_pkg::OFS_STAT, 8'h80);
			end
			rd(sat_pkg::OFS_STAT, 8'h80, 1'b0);
			lo = 1'b0;
			repeat (128) begin
				@(posedge core_clk);
				lo = lo | ~txd_out;
			end
			chk({7'h00, lo}, 8'h00);
		end
		d = 8'($urandom);
		u_remote.send(d, nb, pe, odd, ns, 1'b1, 1'b0);
		chk({7'h00, er_irq}, 8'h01);
		rd(sat_pkg::OFS_STAT, 8'h88, 1'b0);
		rd(sat_pkg::OFS_RXD, msk(d, 7), 1'b0);
		wr(sat_pkg::OFS_STAT, 8'h80);
		rd(sat_pkg::OFS_STAT, 8'h80, 1'b0);
		t = 8'($urandom);
		u_remote.send(t, nb, pe, odd, ns, 1'b0, 1'b0);
		d = 8'($urandom);
		u_remote.send(d, nb, pe, odd, ns, 1'b0, 1'b1);
		wr(sat_pkg::OFS_STAT, 8'h80);
		rd(sat_pkg::OFS_STAT, 8'hF0, 1'b0);
		rd(sat_pkg::OFS_RXD, msk(t, 7), 1'b0);
		wr(sat_pkg::OFS_STAT, 8'h80);
		rd(sat_pkg::OFS_STAT, 8'h80, 1'b0);
		wr(sat_pkg::OFS_CTRL, 8'h00);
		wr(sat_pkg::OFS_MODE, 8'h80);
		repeat (64) @(posedge core_clk);
		wr(sat_pkg::OFS_CTRL, 8'hA2);
		#1 chk({6'h00, txd_oe, sclk_oe}, 8'h02);
		t = 8'($urandom);
		wr(sat_pkg::OFS_TXD, t);
		rd(sat_pkg::OFS_STAT, 8'h80, 1'b0);
		wr(sat_pkg::OFS_STAT, 8'h7F);
		u_remote.grab_sync(g);
		chk(g, t);
		chk({7'h00, tx_irq}, 8'h01);
		summarize();
	end
endmodule
